// ==== design/fidc_consts.vh ====
// Constants for the serial flash command controller
`ifndef FIDC_CONSTS_VH
`define FIDC_CONSTS_VH

// APB register offsets
`define FIDC_OFS_CTRL 8'h00
`define FIDC_OFS_ADDR 8'h04
`define FIDC_OFS_WDATA 8'h08
`define FIDC_OFS_RDATA 8'h0c
`define FIDC_OFS_STAT 8'h10
`define FIDC_OFS_AUX 8'h14

// Control register fields
`define FIDC_F_OP 7:0
`define FIDC_F_AB 10:8
`define FIDC_B_DUM 11
`define FIDC_F_WB 14:12
`define FIDC_F_RB 23:16
`define FIDC_B_PRE 24
`define FIDC_B_POLL 25

// Aux register fields
`define FIDC_F_PREOP 7:0
`define FIDC_F_POLLOP 15:8

// Status register bits
`define FIDC_B_BUSY 0
`define FIDC_B_WIP 1
`define FIDC_B_REF 2

// Limits and reset values
`define FIDC_AB_THREE 3'h3
`define FIDC_AB_FOUR 3'h4
`define FIDC_WB_MAX 3'h4
`define FIDC_RST_AUX 16'h0000

// Bit counts of frame phases
`define FIDC_OPC_BITS 12'h008
`define FIDC_DUMMY_BITS 12'h008
`define FIDC_POLL_RX 11'h008

// Device status byte bit positions
`define FIDC_DEV_WIP 0

// Timing in cycles of clk
`define FIDC_HALF 3'h4
`define FIDC_GAP 4'h8

`endif

// ==== design/fidc_sync.v ====
// Two flip-flop synchroniser for one level
`timescale 1ns/1ps
module fidc_sync (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Level in and synchronised level out
  input wire d,
  output reg q
);
  reg meta; // First stage, read only by q

  // Two stages, cleared to zero at reset
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // fidc_sync

// ==== design/fidc_top.v ====
// Host controller driving a serial NOR flash over single-line pins
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "fidc_consts.vh"
module fidc_top (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Flash pins
  output reg flash_cs_n,
  output reg flash_sclk,
  output reg flash_mosi,
  input wire flash_miso
);
  // Frame sequencer states
  localparam S_IDLE = 3'h0;
  localparam S_LOAD = 3'h1;
  localparam S_LOW = 3'h2;
  localparam S_HIGH = 3'h3;
  localparam S_END = 3'h4;
  localparam S_GAP = 3'h5;

  // Frame kinds
  localparam K_PRE = 2'h0;
  localparam K_MAIN = 2'h1;
  localparam K_POLL = 2'h2;

  wire rst_n; // Synchronised reset
  wire miso_s; // Synchronised serial input

  // Command registers
  reg [7:0] cmd_op; // Opcode
  reg [2:0] cmd_ab; // Address bytes, 0, 3 or 4
  reg cmd_dum; // Eight dummy clocks
  reg [2:0] cmd_wb; // Write data bytes
  reg [7:0] cmd_rb; // Read data bytes
  reg cmd_pre; // Send prefix frame first
  reg cmd_poll; // Poll status afterwards
  reg [31:0] cmd_addr; // Address
  reg [31:0] cmd_wdata; // Write data, MSB first
  reg [15:0] aux; // Prefix and poll opcodes
  reg [31:0] rdata; // Last bytes read
  reg [7:0] poll_byte; // Last status byte polled
  reg refused; // Sticky: start refused
  reg busy; // Sequence running

  // Sequencer registers
  reg [2:0] state;
  reg [1:0] kind;
  reg [2:0] div; // Half period counter
  reg [3:0] gap; // Deselect time counter
  reg [71:0] sr; // Outgoing bits
  reg [11:0] left; // Bits left in frame
  reg [10:0] rx_total; // Read bits of frame

  // APB decode helpers
  wire acc = psel & penable & ~pready;
  wire wr_done = psel & penable & pready & pwrite;
  wire hit_ctrl = (paddr == `FIDC_OFS_CTRL);
  wire hit_stat = (paddr == `FIDC_OFS_STAT);

  // Validity of a new command word
  // A bad field or a running sequence refuses the start and sets refused
  wire [2:0] new_ab = pwdata[`FIDC_F_AB];
  wire [2:0] new_wb = pwdata[`FIDC_F_WB];
  wire ab_ok = (new_ab == 3'h0) | (new_ab == `FIDC_AB_THREE) |
               (new_ab == `FIDC_AB_FOUR);
  wire wb_ok = (new_wb <= `FIDC_WB_MAX);
  wire start_req = wr_done & hit_ctrl;
  wire start_ok = start_req & ~busy & ab_ok & wb_ok;

  // Main frame layout: address top aligned, data right behind it
  // Only the low cmd_ab bytes of cmd_addr go out, MSB first
  wire [5:0] a_shift = {(`FIDC_AB_FOUR - cmd_ab), 3'h0};
  wire [5:0] w_shift = {cmd_ab, 3'h0};
  wire [31:0] a_top = cmd_addr << a_shift;
  // Write bytes beyond cmd_wb are masked so dummy and read phases send zeros
  wire [5:0] wb_bits = {cmd_wb, 3'h0};
  wire [31:0] w_keep = cmd_wdata & ~(32'hffffffff >> wb_bits);
  wire [63:0] body = {a_top, 32'h0} | ({w_keep, 32'h0} >> w_shift);
  wire [11:0] main_bits = `FIDC_OPC_BITS + {6'h0, cmd_ab, 3'h0} +
                          {6'h0, cmd_wb, 3'h0} +
                          (cmd_dum ? `FIDC_DUMMY_BITS : 12'h000) +
                          {1'b0, cmd_rb, 3'h0};

  // Read phase holds the final rx_total bits of the frame
  // half_done marks the last cycle of a four cycle half period
  wire in_rx = ({1'b0, left} <= {2'h0, rx_total});
  wire half_done = (div == `FIDC_HALF - 3'h1);

  // Reset release and serial input crossing
  // The device drives miso from sclk, not clk, so it is synchronised
  fidc_sync u_rst (
    .clk(clk),
    .arst_n(nrst),
    .d(1'b1),
    .q(rst_n)
  );
  fidc_sync u_miso (
    .clk(clk),
    .arst_n(rst_n),
    .d(flash_miso),
    .q(miso_s)
  );

  // APB answer: one wait state, data and error registered
  // pready is high for one cycle, one cycle after the first access edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc;
      if (acc) begin
        pslverr <= 1'b0;
        prdata <= 32'h0;
        if (paddr == `FIDC_OFS_CTRL) begin
          prdata <= {6'h0, cmd_poll, cmd_pre, cmd_rb, 1'b0, cmd_wb,
                     cmd_dum, cmd_ab, cmd_op};
        end else if (paddr == `FIDC_OFS_ADDR) begin
          prdata <= cmd_addr;
        end else if (paddr == `FIDC_OFS_WDATA) begin
          prdata <= cmd_wdata;
        end else if (paddr == `FIDC_OFS_RDATA) begin
          prdata <= rdata;
        end else if (paddr == `FIDC_OFS_STAT) begin
          prdata <= {21'h0, poll_byte, refused, poll_byte[`FIDC_DEV_WIP], busy};
        end else if (paddr == `FIDC_OFS_AUX) begin
          prdata <= {16'h0, aux};
        end else begin
          // Unmapped: error with zero data
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Software-written registers
  // ADDR, WDATA and AUX are dropped silently while a sequence runs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_op <= 8'h0;
      cmd_ab <= 3'h0;
      cmd_dum <= 1'b0;
      cmd_wb <= 3'h0;
      cmd_rb <= 8'h0;
      cmd_pre <= 1'b0;
      cmd_poll <= 1'b0;
      cmd_addr <= 32'h0;
      cmd_wdata <= 32'h0;
      aux <= `FIDC_RST_AUX;
      refused <= 1'b0;
    end else begin
      // Command word only taken while idle
      if (start_ok) begin
        cmd_op <= pwdata[`FIDC_F_OP];
        cmd_ab <= new_ab;
        cmd_dum <= pwdata[`FIDC_B_DUM];
        cmd_wb <= new_wb;
        cmd_rb <= pwdata[`FIDC_F_RB];
        cmd_pre <= pwdata[`FIDC_B_PRE];
        cmd_poll <= pwdata[`FIDC_B_POLL];
      end
      // Address, data and opcodes frozen during a sequence
      if (wr_done & ~busy & (paddr == `FIDC_OFS_ADDR)) begin
        cmd_addr <= pwdata;
      end
      if (wr_done & ~busy & (paddr == `FIDC_OFS_WDATA)) begin
        cmd_wdata <= pwdata;
      end
      if (wr_done & ~busy & (paddr == `FIDC_OFS_AUX)) begin
        aux <= pwdata[15:0];
      end
      // Refused flag: a new refusal wins over a clear
      if (start_req & ~start_ok) begin
        refused <= 1'b1;
      end else if (wr_done & hit_stat & pwdata[`FIDC_B_REF]) begin
        refused <= 1'b0;
      end
    end
  end

  // Frame sequencer and serial pins
  // Each bit is four cycles low then four high, clock idle low
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      kind <= K_MAIN;
      busy <= 1'b0;
      div <= 3'h0;
      gap <= 4'h0;
      sr <= 72'h0;
      left <= 12'h0;
      rx_total <= 11'h0;
      rdata <= 32'h0;
      poll_byte <= 8'h0;
      flash_cs_n <= 1'b1;
      flash_sclk <= 1'b0;
      flash_mosi <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          // Start: write enable frame first when asked
          // busy rises here so further CTRL writes are refused
          if (start_ok) begin
            busy <= 1'b1;
            kind <= pwdata[`FIDC_B_PRE] ? K_PRE : K_MAIN;
            state <= S_LOAD;
          end
        end
        S_LOAD: begin
          // Open frame with opcode MSB first
          // Chip select falls with clock low and bit 7 already on mosi
          div <= 3'h0;
          flash_cs_n <= 1'b0;
          flash_sclk <= 1'b0;
          state <= S_LOW;
          if (kind == K_PRE) begin
            sr <= {aux[`FIDC_F_PREOP], 64'h0};
            flash_mosi <= aux[7];
            left <= `FIDC_OPC_BITS;
            rx_total <= 11'h0;
          end else if (kind == K_POLL) begin
            sr <= {aux[`FIDC_F_POLLOP], 64'h0};
            flash_mosi <= aux[15];
            left <= `FIDC_OPC_BITS + {1'b0, `FIDC_POLL_RX};
            rx_total <= `FIDC_POLL_RX;
          end else begin
            // Exact bit count so the frame ends on its boundary
            sr <= {cmd_op, body};
            flash_mosi <= cmd_op[7];
            left <= main_bits;
            rx_total <= {cmd_rb, 3'h0};
          end
        end
        S_LOW: begin
          // Clock low half; rising edge samples device data
          // miso_s lags the pin by two cycles, well inside this half
          div <= div + 3'h1;
          if (half_done) begin
            div <= 3'h0;
            flash_sclk <= 1'b1;
            state <= S_HIGH;
            if (in_rx & (kind == K_POLL)) begin
              poll_byte <= {poll_byte[6:0], miso_s};
            end else if (in_rx) begin
              rdata <= {rdata[30:0], miso_s};
            end
          end
        end
        S_HIGH: begin
          // Falling edge moves to next outgoing bit
          // After the last bit mosi holds until deselect
          div <= div + 3'h1;
          if (half_done) begin
            div <= 3'h0;
            flash_sclk <= 1'b0;
            sr <= {sr[70:0], 1'b0};
            left <= left - 12'h001;
            if (left == 12'h001) begin
              state <= S_END;
            end else begin
              flash_mosi <= sr[70];
              state <= S_LOW;
            end
          end
        end
        S_END: begin
          // Deselect only with clock low
          // Last fall was half a period ago; close the frame now
          div <= div + 3'h1;
          if (half_done) begin
            div <= 3'h0;
            flash_cs_n <= 1'b1;
            flash_mosi <= 1'b0;
            gap <= 4'h0;
            state <= S_GAP;
          end
        end
        S_GAP: begin
          // Deselect time, then choose the next frame
          // Poll frames repeat while the polled byte reports a write
          gap <= gap + 4'h1;
          if (gap == `FIDC_GAP - 4'h1) begin
            if (kind == K_PRE) begin
              kind <= K_MAIN;
              state <= S_LOAD;
            end else if ((kind == K_MAIN) & cmd_poll) begin
              kind <= K_POLL;
              state <= S_LOAD;
            end else if ((kind == K_POLL) & poll_byte[`FIDC_DEV_WIP]) begin
              state <= S_LOAD;
            end else begin
              busy <= 1'b0;
              state <= S_IDLE;
            end
          end
        end
        // Unused state codes fall back to idle with the bus released
        default: begin
          state <= S_IDLE;
          busy <= 1'b0;
          flash_cs_n <= 1'b1;
        end
      endcase
    end
  end
endmodule // fidc_top

// ==== test/fidc_props.sv ====
// Bus and serial pin checker for the flash controller
`timescale 1ns/1ps
module fidc_props (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // APB bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Flash pins
  input wire flash_cs_n,
  input wire flash_sclk,
  input wire flash_mosi,
  input wire flash_miso
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Bits clocked in the current frame, modulo one byte
  reg [2:0] bits;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) bits <= 3'h0;
    else if (flash_cs_n) bits <= 3'h0;
    else if ($rose(flash_sclk)) bits <= bits + 3'h1;
  end
  // One serial clock pulse: four cycles high, then low
  sequence sck_pulse;
    flash_sclk [*4] ##1 !flash_sclk;
  endsequence
  idle_clock_low_a: assert property (flash_cs_n |-> !flash_sclk)
    else $error("serial clock high outside frame");
  frame_open_a: assert property ($fell(flash_cs_n) |-> !flash_sclk [*4] ##1 sck_pulse)
    else $error("frame start timing wrong");
  pulse_width_a: assert property ($rose(flash_sclk) |-> sck_pulse)
    else $error("serial clock high time wrong");
  mosi_stable_a: assert property (flash_sclk |-> $stable(flash_mosi))
    else $error("serial out moved while clock high");
  frame_close_a: assert property ($rose(flash_cs_n) |-> $past(flash_sclk, 5) && !$past(flash_sclk, 4))
    else $error("frame end timing wrong");
  whole_bytes_a: assert property ($rose(flash_cs_n) |-> bits == 3'h0)
    else $error("frame not a whole number of bytes");
  standby_gap_a: assert property ($rose(flash_cs_n) |-> flash_cs_n [*8])
    else $error("gap between frames too short");
  wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("bus answer late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (pready && paddr > 8'h14 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not flagged");
endmodule // fidc_props
bind fidc_top fidc_props u_props (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .flash_cs_n(flash_cs_n), .flash_sclk(flash_sclk),
  .flash_mosi(flash_mosi), .flash_miso(flash_miso));

// ==== test/fidc_flash_model.sv ====
// Behavioural serial flash answering the controller's frames
`timescale 1ns/1ps
module fidc_flash_model #(
  parameter [7:0] OP_ID = 8'h9f, OP_RS = 8'h05, OP_RC = 8'h15, OP_WS = 8'h01,
  parameter [7:0] OP_WE = 8'h06, OP_SR = 8'h2b, OP_SW = 8'h2f, OP_R3 = 8'h03,
  parameter [7:0] OP_F4 = 8'h0c, OP_C2R = 8'h71,
  parameter [31:0] CRC_ADDR = 32'h0000_0040, // Address of the error flag register
  parameter [23:0] ID_CODE = 24'h5ca1b2, // Arbitrary maker and part code
  parameter TW = 2000 // Register write time in ns
) (
  // Serial pins
  input wire cs_n,
  input wire sclk,
  input wire mosi,
  output reg miso
);
  reg [7:0] op, st, cf, sc, b;
  reg [31:0] sh, ad;
  integer n, hd;
  initial begin
    miso = 1'b0;
    st = 8'h00;
    cf = 8'h00;
    sc = 8'h00;
    n = 0;
    hd = 999;
  end
  // Byte k of the answer
  function [7:0] val(input integer k);
    reg [31:0] a;
    begin
      a = ad + k;
      if (op == OP_R3) a[31:24] = 8'h00;
      case (op)
        OP_ID: val = (k == 0) ? ID_CODE[23:16] : (k == 1) ? ID_CODE[15:8] : ID_CODE[7:0];
        OP_RS: val = st;
        OP_RC: val = cf;
        OP_SR: val = sc;
        default: val = a[7:0] ^ 8'h5a;
      endcase
    end
  endfunction
  // Frame opens
  always @(negedge cs_n) n = 0;
  // Opcode and address taken on rising edges, MSB first
  always @(posedge sclk) if (!cs_n) begin
    sh = {sh[30:0], mosi};
    n = n + 1;
    if (n == 8) begin
      op = sh[7:0];
      hd = (op == OP_R3) ? 32 : (op == OP_F4) ? 48 : (op == OP_C2R) ? 40 : 8;
      if (op == OP_F4 && st[0]) hd = 999;
      if (op == OP_ID && st[0]) hd = 999;
    end
    if (n == 32 && op == OP_R3) ad = {8'h00, sh[23:0]};
    if (n == 40 && op == OP_F4) ad = sh;
    if (n == 40 && op == OP_C2R) begin
      ad = sh;
      if (st[0] && sh != CRC_ADDR) hd = 999;
    end
  end
  // Data driven on falling edges after the header
  always @(negedge sclk) if (!cs_n && n >= hd) begin
    b = val((n - hd) / 8);
    miso = b[7 - (n - hd) % 8];
  end
  // Frame closes: invert data line, apply writes only at exact boundaries
  always @(posedge cs_n) begin
    miso = ~miso;
    if (op == OP_WE && n == 8) st[1] = 1'b1;
    else if (op == OP_WS && st[1] && !st[0] && (n == 16 || n == 24)) begin
      st[7:2] = (n == 16) ? sh[7:2] : sh[15:10];
      if (n == 24) cf = sh[7:0];
      st[0] = 1'b1;
    end else if (op == OP_SW && st[1] && !st[0] && n == 8) begin
      sc[1] = 1'b1;
      st[1] = 1'b0;
    end
    op = 8'h00;
  end
  // Self-timed write: busy and latch clear together
  always @(posedge st[0]) begin
    #TW;
    st[1:0] = 2'b00;
  end
endmodule // fidc_flash_model

// ==== test/tb_fidc_top.sv ====
// Self-checking bench for the flash command controller
`timescale 1ns/1ps
`include "fidc_consts.vh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fail_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb_fidc_top;
  reg clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0, r;
  wire pready, pslverr, cs_n, sclk, mosi, miso;
  wire [31:0] prdata;
  integer fail_count = 0, check_count = 0, i;
  always #5 clk = ~clk;
  fidc_top uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .flash_cs_n(cs_n), .flash_sclk(sclk), .flash_mosi(mosi), .flash_miso(miso));
  fidc_flash_model dev (.cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso));
  // Report and end the run
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // One bus transfer; data and error taken at the ready edge
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      @(posedge clk);
      while (pready !== 1'b1 && i < 20) begin
        @(posedge clk);
        i = i + 1;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
        fail_count++;
        print_verdict;
      end
    end
  endtask
  // Start a sequence, wait for idle, fetch read data
  task go(input [31:0] c, input [31:0] a, input [31:0] d);
    integer j;
    begin
      apb(1'b1, `FIDC_OFS_ADDR, a);
      apb(1'b1, `FIDC_OFS_WDATA, d);
      apb(1'b1, `FIDC_OFS_CTRL, c);
      j = 0;
      r = 32'h1;
      while (r[0] !== 1'b0 && j < 2000) begin
        apb(1'b0, `FIDC_OFS_STAT, 32'h0);
        j = j + 1;
      end
      if (j == 2000) begin
        fail_count++;
        print_verdict;
      end
      apb(1'b0, `FIDC_OFS_RDATA, 32'h0);
    end
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, `FIDC_OFS_STAT, 32'h0);
    `CHK("status reset", 32'h0, r);
    apb(1'b0, `FIDC_OFS_AUX, 32'h0);
    `CHK("aux reset", 32'h0, r);
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped error", 1'b1, e);
    apb(1'b1, `FIDC_OFS_AUX, 32'h0506);
    apb(1'b0, `FIDC_OFS_AUX, 32'h0);
    `CHK("aux", 32'h0506, r);
    go(32'h0003_009f, 32'h0, 32'h0);
    `CHK("ident", 24'h5ca1b2, r[23:0]);
    go(32'h0001_009f, 32'h0, 32'h0);
    `CHK("ident short", 8'h5c, r[7:0]);
    go(32'h0001_0005, 32'h0, 32'h0);
    `CHK("status byte", 8'h00, r[7:0]);
    go(32'h0300_2001, 32'h0, 32'hbf3c_0000);
    apb(1'b0, `FIDC_OFS_STAT, 32'h0);
    `CHK("polled status", 11'h5e0, r[10:0]);
    go(32'h0001_0015, 32'h0, 32'h0);
    `CHK("config byte", 8'h3c, r[7:0]);
    go(32'h0004_0303, 32'h00ff_fffe, 32'h0);
    `CHK("wrapping read", 32'ha4a5_5a5b, r);
    go(32'h0002_0c0c, 32'h0000_1230, 32'h0);
    `CHK("dummy read", 16'h6a6b, r[15:0]);
    apb(1'b0, `FIDC_OFS_ADDR, 32'h0);
    `CHK("addr readback", 32'h0000_1230, r);
    go(32'h0001_0471, 32'h0000_0213, 32'h0);
    `CHK("config2 read", 8'h49, r[7:0]);
    go(32'h0000_002f, 32'h0, 32'h0);
    go(32'h0001_002b, 32'h0, 32'h0);
    `CHK("lock without enable", 8'h00, r[7:0]);
    go(32'h0100_002f, 32'h0, 32'h0);
    go(32'h0001_002b, 32'h0, 32'h0);
    `CHK("lock set", 8'h02, r[7:0]);
    apb(1'b1, `FIDC_OFS_CTRL, 32'h0001_0005);
    go(32'h0001_0005, 32'h0, 32'h0);
    apb(1'b0, `FIDC_OFS_STAT, 32'h0);
    `CHK("refused flag", 1'b1, r[2]);
    apb(1'b1, `FIDC_OFS_STAT, 32'h4);
    apb(1'b0, `FIDC_OFS_STAT, 32'h0);
    `CHK("refused cleared", 1'b0, r[2]);
    apb(1'b1, `FIDC_OFS_CTRL, 32'h0001_0105);
    apb(1'b0, `FIDC_OFS_STAT, 32'h0);
    `CHK("bad address bytes", 3'h4, r[2:0]);
    print_verdict;
  end
endmodule // tb_fidc_top
